// [logic/ebsr_pkg.sv]
`default_nettype none
package ebsr_pkg;
	localparam int          CLK_MHZ          = 125;
	localparam int          PULL_HIGH_US     = 5;
	localparam int          PULL_HIGH_CYC    = PULL_HIGH_US * CLK_MHZ;
	localparam int          START_WAIT_OSC   = (2 ** 17) + 512;
	localparam int          START_LAT        = 4;
	localparam logic [2:0]  STRETCH_RST      = 3'h1;
	localparam int          MC_OSC           = 4;
	localparam int          BASE_MC          = 2;
	localparam int          CNT_W            = 18;
	localparam int          PH_W             = 6;
	localparam logic [1:0]  MODE_USER        = 2'h0;
	localparam logic [1:0]  MODE_SERIAL_PROG = 2'h1;
	localparam logic [1:0]  MODE_PAR_PROG    = 2'h2;
	typedef enum logic [1:0] {EBSR_IDLE, EBSR_XFER} ebsr_state_t;
endpackage : ebsr_pkg
`default_nettype wire

// [logic/ebsr_timer_if.sv]
`default_nettype none
interface ebsr_timer_if;
	logic load;
	logic done;
	modport ctrl (output load, input done);
	modport tmr  (input load, output done);
endinterface : ebsr_timer_if
`default_nettype wire

// [logic/ebsr_start_timer.sv]
`default_nettype none
module ebsr_start_timer
	import ebsr_pkg::*;
#(
	parameter int WAIT_CYC = START_WAIT_OSC
) (
	input  wire logic clk_i,
	input  wire logic resetn_i,
	ebsr_timer_if.tmr t
);
	logic [CNT_W-1:0] cnt_r;
	logic [CNT_W-1:0] cnt_nxt;
	logic             done_r;
	logic             done_nxt;

	always_comb begin
		cnt_nxt  = cnt_r;
		done_nxt = done_r;
		if (t.load) begin
			cnt_nxt  = CNT_W'(WAIT_CYC - 1);
			done_nxt = 1'b0;
		end else if (!done_r) begin
			if (cnt_r == '0)
				done_nxt = 1'b1;
			else
				cnt_nxt = cnt_r - 1'b1;
		end
	end

	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			cnt_r  <= '0;
			done_r <= 1'b0;
		end else begin
			cnt_r  <= cnt_nxt;
			done_r <= done_nxt;
		end
	end

	assign t.done = done_r;
endmodule : ebsr_start_timer
`default_nettype wire

// [logic/ebsr_bus.sv]
`default_nettype none
module ebsr_bus
	import ebsr_pkg::*;
#(
	parameter int START_WAIT = START_WAIT_OSC
) (
	// Clock and reset
	input  wire logic        clk_i,
	input  wire logic        resetn_i,
	// Device reset pin, active high, asynchronous to clk
	input  wire logic        rst_pin_i,
	// Mode select pins
	input  wire logic        serial_prog_sel_i,
	input  wire logic        par_prog_sel_i,
	input  wire logic        external_program_access_i,
	// Stretch control field
	input  wire logic        stretch_wr_i,
	input  wire logic [2:0]  stretch_sel_i,
	output logic      [2:0]  stretch_sel_o,
	// Transfer request from core
	input  wire logic        xfer_req_i,
	input  wire logic        xfer_write_i,
	output logic             xfer_busy_o,
	output logic             xfer_done_o,
	// External bus pins, active low strobes
	output logic             addr_latch_o,
	output logic             program_fetch_strobe_n_o,
	output logic             rd_strobe_n_o,
	output logic             wr_strobe_n_o,
	output logic             addr_drive_o,
	// Start-up status
	output logic             running_o,
	output logic      [1:0]  mode_o,
	output logic             ext_prog_o
);
	// Two-stage synchronisers for pin inputs
	logic [1:0] rst_s_r, ser_s_r, par_s_r, ea_s_r;
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			rst_s_r <= 2'h0;
			ser_s_r <= 2'h0;
			par_s_r <= 2'h0;
			ea_s_r  <= 2'h0;
		end else begin
			rst_s_r <= {rst_s_r[0], rst_pin_i};
			ser_s_r <= {ser_s_r[0], serial_prog_sel_i};
			par_s_r <= {par_s_r[0], par_prog_sel_i};
			ea_s_r  <= {ea_s_r[0], external_program_access_i};
		end
	end
	logic rst_q, ser_q, par_q, ea_q;
	assign rst_q = rst_s_r[1];
	assign ser_q = ser_s_r[1];
	assign par_q = par_s_r[1];
	assign ea_q  = ea_s_r[1];

	// Reset pin qualification: two clocks high resets the device
	logic [1:0] rst_cnt_r, rst_cnt_nxt;
	logic       in_reset_r, in_reset_nxt;
	logic       rst_prev_r, rst_prev_nxt;
	logic [1:0] mode_r, mode_nxt;
	logic       ext_r, ext_nxt;
	logic       run_r, run_nxt;
	ebsr_timer_if tif ();

	always_comb begin
		rst_cnt_nxt  = rst_q ? ((rst_cnt_r == 2'h2) ? rst_cnt_r : rst_cnt_r + 1'b1) : 2'h0;
		in_reset_nxt = in_reset_r;
		rst_prev_nxt = in_reset_r;
		mode_nxt     = mode_r;
		ext_nxt      = ext_r;
		run_nxt      = run_r;
		tif.load     = 1'b0;
		if (rst_q && rst_cnt_r == 2'h1) begin
			in_reset_nxt = 1'b1;
			run_nxt      = 1'b0;
		end else if (!rst_q && in_reset_r) begin
			in_reset_nxt = 1'b0;
			tif.load     = 1'b1;
			// Sample mode pins at release; setup is the programmer's job
			if (par_q) begin
				mode_nxt = MODE_PAR_PROG;
				ext_nxt  = 1'b0;
			end else if (ser_q) begin
				mode_nxt = MODE_SERIAL_PROG;
				ext_nxt  = 1'b0;
			end else begin
				mode_nxt = MODE_USER;
				ext_nxt  = ea_q;
			end
		end else if (!in_reset_r && !rst_prev_r && tif.done && !run_r) begin
			run_nxt = 1'b1;
		end
	end

	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			rst_cnt_r  <= 2'h0;
			in_reset_r <= 1'b1;
			rst_prev_r <= 1'b1;
			mode_r     <= MODE_USER;
			ext_r      <= 1'b0;
			run_r      <= 1'b0;
		end else begin
			rst_cnt_r  <= rst_cnt_nxt;
			in_reset_r <= in_reset_nxt;
			rst_prev_r <= rst_prev_nxt;
			mode_r     <= mode_nxt;
			ext_r      <= ext_nxt;
			run_r      <= run_nxt;
		end
	end

	// Timer trimmed by the synchroniser and hand-off clocks, so the start
	// never overruns the wait measured from the pin
	ebsr_start_timer #(.WAIT_CYC(START_WAIT - START_LAT)) u_timer (
		.clk_i    (clk_i),
		.resetn_i (resetn_i),
		.t        (tif.tmr)
	);

	// Stretch field and transfer engine; one clk is one oscillator period
	logic [2:0]      stretch_r, stretch_nxt;
	logic [2:0]      cur_r, cur_nxt;
	logic            wr_r, wr_nxt;
	logic [PH_W-1:0] ph_r, ph_nxt;
	ebsr_state_t     st_r, st_nxt;
	logic            ale_r, ale_nxt, rd_r, rd_nxt, wrs_r, wrs_nxt, adr_r, adr_nxt;
	logic            done_r, done_nxt;
	logic [PH_W-1:0] last_ph;
	logic            str;

	// Strobe window in oscillator periods; half periods round to whole ones
	assign str     = (cur_r != 3'h0);
	assign last_ph = PH_W'((BASE_MC + 32'(cur_r)) * MC_OSC - 1);

	always_comb begin
		stretch_nxt = stretch_r;
		// A device reset restores the default code just like power-on
		if (in_reset_r)
			stretch_nxt = STRETCH_RST;
		else if (stretch_wr_i)
			stretch_nxt = stretch_sel_i;
		cur_nxt     = cur_r;
		wr_nxt      = wr_r;
		ph_nxt      = ph_r;
		st_nxt      = st_r;
		done_nxt    = 1'b0;
		// Latch idles high, so it rises with the strobe or one clock after it
		ale_nxt     = 1'b1;
		rd_nxt      = 1'b0;
		wrs_nxt     = 1'b0;
		adr_nxt     = 1'b0;
		unique case (st_r)
			EBSR_IDLE: begin
				if (xfer_req_i && run_r) begin
					st_nxt  = EBSR_XFER;
					cur_nxt = stretch_r;
					wr_nxt  = xfer_write_i;
					ph_nxt  = '0;
				end
			end
			EBSR_XFER: begin
				ph_nxt = ph_r + 1'b1;
				if (ph_r == last_ph) begin
					st_nxt   = EBSR_IDLE;
					done_nxt = 1'b1;
				end
			end
		endcase
		if (st_nxt == EBSR_XFER) begin
			// Phase counted in the cycle being produced
			// Latch high ph0; strobe from ph1 (ph2 stretched); address from ph0
			adr_nxt = 1'b1;
			ale_nxt = (ph_nxt == '0);
			if ((ph_nxt >= (str ? PH_W'(2) : PH_W'(1))) &&
			    (ph_nxt < (str ? last_ph : last_ph + 1'b1))) begin
				rd_nxt  = !wr_nxt;
				wrs_nxt = wr_nxt;
			end
			if (st_r == EBSR_IDLE) begin
				ale_nxt = 1'b1;
				rd_nxt  = 1'b0;
				wrs_nxt = 1'b0;
			end
		end
	end

	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			stretch_r <= STRETCH_RST;
			cur_r     <= STRETCH_RST;
			wr_r      <= 1'b0;
			ph_r      <= '0;
			st_r      <= EBSR_IDLE;
			ale_r     <= 1'b1;
			rd_r      <= 1'b0;
			wrs_r     <= 1'b0;
			adr_r     <= 1'b0;
			done_r    <= 1'b0;
		end else begin
			stretch_r <= stretch_nxt;
			cur_r     <= cur_nxt;
			wr_r      <= wr_nxt;
			ph_r      <= ph_nxt;
			st_r      <= st_nxt;
			ale_r     <= ale_nxt;
			rd_r      <= rd_nxt;
			wrs_r     <= wrs_nxt;
			adr_r     <= adr_nxt;
			done_r    <= done_nxt;
		end
	end

	// During reset fetch and latch are high within four clocks of the pin rising, well inside 5 us
	assign addr_latch_o             = !run_r | ale_r;
	assign program_fetch_strobe_n_o = 1'b1;
	assign rd_strobe_n_o            = !rd_r;
	assign wr_strobe_n_o            = !wrs_r;
	assign addr_drive_o             = adr_r;
	assign xfer_busy_o              = (st_r != EBSR_IDLE);
	assign xfer_done_o              = done_r;
	assign stretch_sel_o            = stretch_r;
	assign running_o                = run_r;
	assign mode_o                   = mode_r;
	assign ext_prog_o               = ext_r;
endmodule : ebsr_bus
`default_nettype wire

// [sim/ebsr_bus_checker.sv]
`default_nettype none
module ebsr_bus_checker
	import ebsr_pkg::*;
#(
	parameter int START_WAIT = 16
) (
	// Watched ports
	input wire logic       clk_i,
	input wire logic       resetn_i,
	input wire logic       rst_pin_i,
	input wire logic       stretch_wr_i,
	input wire logic [2:0] stretch_sel_i,
	input wire logic [2:0] stretch_sel_o,
	input wire logic       xfer_req_i,
	input wire logic       xfer_busy_o,
	input wire logic       xfer_done_o,
	input wire logic       addr_latch_o,
	input wire logic       rd_strobe_n_o,
	input wire logic       wr_strobe_n_o,
	input wire logic       addr_drive_o,
	input wire logic       running_o,
	input wire logic [1:0] mode_o,
	input wire logic       ext_prog_o
);
	logic [2:0]  code_r;
	logic [7:0]  cyc_r;
	logic [31:0] wait_r;
	wire logic take = xfer_req_i && running_o && !xfer_busy_o;
	wire logic strb_n = rd_strobe_n_o & wr_strobe_n_o;
	// Code frozen at the taking edge, so a write mid-transfer is not blamed
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			code_r <= STRETCH_RST;
			cyc_r  <= 8'h00;
			wait_r <= 32'h0;
		end else begin
			code_r <= take ? stretch_sel_o : code_r;
			cyc_r  <= take ? 8'h01 : cyc_r + 8'h01;
			// Clocks spent with the pin low and the device not yet running
			wait_r <= (rst_pin_i || running_o) ? 32'h0 : wait_r + 32'h1;
		end
	end
	default clocking @(posedge clk_i); endclocking
	default disable iff (!resetn_i);
	sequence s_lead_short;
		$past(addr_drive_o) && $past(addr_latch_o);
	endsequence
	sequence s_lead_long;
		$past(addr_drive_o, 2) && $past(addr_latch_o, 2) && !$past(addr_latch_o);
	endsequence
	sequence s_latch_late;
		!addr_latch_o ##1 addr_latch_o;
	endsequence
	a_reset_code: assert property ($rose(resetn_i) |-> stretch_sel_o == STRETCH_RST)
		else $error("bad reset code");
	a_done_timing: assert property (xfer_done_o |-> cyc_r == {3'h0, code_r, 2'h0} + 8'h09)
		else $error("done off time");
	a_lead_short: assert property ($fell(strb_n) && code_r == 3'h0 |-> s_lead_short)
		else $error("short lead");
	a_lead_long: assert property ($fell(strb_n) && code_r != 3'h0 |-> s_lead_long)
		else $error("long lead");
	a_latch_short: assert property ($rose(strb_n) && code_r == 3'h0 |-> $rose(addr_latch_o))
		else $error("latch rise off strobe");
	a_latch_long: assert property ($rose(strb_n) && code_r != 3'h0 |-> s_latch_late)
		else $error("latch rise not late");
	a_pull_high: assert property ($rose(rst_pin_i) |-> ##[1:625] addr_latch_o)
		else $error("latch not pulled");
	a_start_wait: assert property (!running_o |-> wait_r < START_WAIT)
		else $error("start late");
	a_reset_enter: assert property ($rose(rst_pin_i) ##1 rst_pin_i |-> ##[1:4] !running_o)
		else $error("reset pin ignored");
	a_prog_ignores: assert property (mode_o != MODE_USER |-> !ext_prog_o)
		else $error("access pin used");
	a_code_write: assert property (stretch_wr_i |=> stretch_sel_o == $past(stretch_sel_i))
		else $error("code not written");
endmodule : ebsr_bus_checker
bind ebsr_bus ebsr_bus_checker #(.START_WAIT(START_WAIT)) u_chk (.*);
`default_nettype wire

// [sim/ebsr_prog_model.sv]
`default_nettype none
module ebsr_prog_model #(
	parameter int HOLD = 24
) (
	// Oscillator
	input  wire logic clk_i,
	// Reset and mode pins toward the device
	output var logic  rst_pin_o,
	output var logic  ser_o,
	output var logic  par_o,
	output var logic  epa_o
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		rst_pin_o = 1'b0;
		{par_o, ser_o} = 2'h0;
		epa_o = 1'b1;
	end
	task automatic boot(input logic [1:0] m);
		@(negedge clk_i);
		{par_o, ser_o} = m;
		@(negedge clk_i);
		rst_pin_o = 1'b1;
		repeat (4) @(negedge clk_i);
		rst_pin_o = 1'b0;
		repeat (HOLD) @(negedge clk_i);
	endtask : boot
endmodule : ebsr_prog_model
`default_nettype wire

// [sim/ebsr_bus_test.sv]
`default_nettype none
module ebsr_bus_test import ebsr_pkg::*;;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int SW = 16;
	logic       clk_i = 1'b0, resetn_i = 1'b0, stretch_wr_i = 1'b0;
	logic       xfer_req_i = 1'b0, xfer_write_i = 1'b0;
	logic [2:0] stretch_sel_i = 3'h0, stretch_sel_o;
	logic       rst_pin_i, serial_prog_sel_i, par_prog_sel_i, external_program_access_i;
	logic       xfer_busy_o, xfer_done_o, addr_latch_o, program_fetch_strobe_n_o;
	logic       rd_strobe_n_o, wr_strobe_n_o, addr_drive_o, running_o, ext_prog_o;
	logic [1:0] mode_o;
	int         err_count = 0, checks = 0;
	always #4 clk_i = ~clk_i;
	ebsr_bus #(.START_WAIT(SW)) DUT (.*);
	ebsr_prog_model #(.HOLD(SW + 8)) prog (.clk_i(clk_i), .rst_pin_o(rst_pin_i),
		.ser_o(serial_prog_sel_i), .par_o(par_prog_sel_i), .epa_o(external_program_access_i));
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checks++;
		if (got !== exp) begin
			err_count++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic wait_run;
		for (int n = 0; n < 64 && running_o !== 1'b1; n++) @(negedge clk_i);
	endtask : wait_run
	task automatic put_code(input logic [2:0] c);
		stretch_sel_i = c;
		stretch_wr_i = 1'b1;
		@(negedge clk_i);
		stretch_wr_i = 1'b0;
	endtask : put_code
	// Request is dropped after the taking edge; counts cycles and active-strobe cycles
	task automatic xfer(input logic w, output logic [7:0] k, output logic [7:0] lo);
		k = 8'h00;
		lo = 8'h00;
		xfer_write_i = w;
		xfer_req_i = 1'b1;
		do begin
			@(negedge clk_i);
			if (k == 8'h00)
				xfer_req_i = 1'b0;
			k++;
			lo += 8'(w ? !wr_strobe_n_o : !rd_strobe_n_o);
		end while (xfer_done_o !== 1'b1 && k < 8'h3c);
	endtask : xfer
	task automatic t_codes;
		logic [7:0] k, lo;
		for (int c = 0; c < 8; c++) begin
			put_code(3'(c));
			xfer(c[0], k, lo);
			chk(k, 8'(4 * c + 9));
			chk(lo, 8'(c == 0 ? 7 : 4 * c + 5));
		end
		$display("t_codes finished");
	endtask : t_codes
	task automatic t_mid;
		logic [7:0] k, lo;
		put_code(3'h1);
		fork
			xfer(1'b0, k, lo);
			begin
				repeat (3) @(negedge clk_i);
				put_code(3'h7);
			end
		join
		chk(k, 8'h0d);
		xfer(1'b1, k, lo);
		chk(k, 8'h25);
		$display("t_mid finished");
	endtask : t_mid
	task automatic t_prog;
		for (int m = 0; m < 3; m++) begin
			prog.boot(2'(m));
			wait_run;
			chk({7'h00, running_o}, 8'h01);
			chk({6'h00, mode_o}, 8'(m));
			chk({7'h00, ext_prog_o}, 8'(m == 0));
			chk({5'h00, stretch_sel_o}, 8'h01);
		end
		$display("t_prog finished");
	endtask : t_prog
	task automatic wrap_up;
		$display("checks=%0d err_count=%0d", checks, err_count);
		if (err_count == 0 && checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : wrap_up
	initial begin
		#200000;
		err_count++;
		wrap_up;
	end
	initial begin
		repeat (10) @(negedge clk_i);
		resetn_i = 1'b1;
		chk({5'h00, stretch_sel_o}, 8'h01);
		chk({7'h00, addr_latch_o}, 8'h01);
		chk({7'h00, program_fetch_strobe_n_o}, 8'h01);
		wait_run;
		chk({7'h00, running_o}, 8'h01);
		t_codes;
		t_mid;
		t_prog;
		wrap_up;
	end
endmodule : ebsr_bus_test
`default_nettype wire
